// >>> hpbp_pkg.sv
// Constants for the host parallel bus port
`default_nettype none
package hpbp_pkg;
  localparam int HPBP_DATA_W = 8;
  localparam int HPBP_ADDR_W = 6;
  localparam int HPBP_DATA_LSB = 0;
  localparam int HPBP_DATA_MSB = 7;
  localparam logic [7:0] HPBP_REG_RESET = 8'h00;
  localparam logic [7:0] HPBP_IDLE_DATA = 8'h00;
endpackage : hpbp_pkg
`default_nettype wire

// >>> hpbp_port.sv
// Host parallel bus port: strobe-timed register access from a host CPU
`default_nettype none
module hpbp_port
  import hpbp_pkg::*;
#(
  parameter int DATA_W = HPBP_DATA_W,
  parameter int ADDR_W = HPBP_ADDR_W
)
(
  input wire logic REF_CLK_IN, // System clock
  input wire logic RESETN_IN, // Async reset, active low
  input wire logic CHIP_SELECT_N_IN, // Chip select, active low
  input wire logic READ_STROBE_N_IN, // Read strobe, active low
  input wire logic WRITE_STROBE_N_IN, // Write strobe, active low
  input wire logic [ADDR_W-1:0] REGISTER_SELECT_IN, // Register address
  input wire logic [DATA_W-1:0] HOST_DATA_BUS_IN, // Data bus level in
  output logic [DATA_W-1:0] HOST_DATA_BUS_OUT, // Data bus drive value
  output logic HOST_DATA_BUS_OE_OUT, // Data bus drive enable
  output logic READ_START_OUT, // One-cycle pulse at read start
  output logic WRITE_DONE_OUT // One-cycle pulse at write commit
);

  // Refuse widths that the store and the byte lanes cannot serve
  if (DATA_W != HPBP_DATA_W || ADDR_W < 1 || ADDR_W > 8)
  begin : g_bad_width
    $error("hpbp_port: unsupported width parameters");
  end

  // Direction decode: selected, own strobe low, other strobe high
  function automatic logic strobe_active(input logic sel_in, input logic own_n_in, input logic other_n_in);
    strobe_active = sel_in && !own_n_in && other_n_in;
  endfunction : strobe_active

  ////////////////////////////////////////////////////////////////////
  // Strobe history and edge decode
  localparam int NREG = 1 << ADDR_W;

  logic [DATA_W-1:0] regs_r [NREG];
  logic wr_act_r;
  logic rd_act_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic [DATA_W-1:0] dout_r;
  logic oe_r;
  logic rd_start_r;
  logic wr_done_r;

  wire sel = !CHIP_SELECT_N_IN;
  wire wr_act = strobe_active(sel, WRITE_STROBE_N_IN, READ_STROBE_N_IN);
  wire rd_act = strobe_active(sel, READ_STROBE_N_IN, WRITE_STROBE_N_IN);
  wire both_low = sel && !READ_STROBE_N_IN && !WRITE_STROBE_N_IN;
  wire wr_rise = wr_act_r && !wr_act;
  wire rd_fall = rd_act && !rd_act_r;
  wire [DATA_W-1:0] rd_word = regs_r[REGISTER_SELECT_IN];
  wire [DATA_W-1:0] dout_nxt = rd_act ? rd_word : DATA_W'(HPBP_IDLE_DATA);
  wire oe_nxt = rd_act;

  ////////////////////////////////////////////////////////////////////
  // Strobe history, one cycle behind the pins
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end
    else
    begin
      wr_act_r <= wr_act;
      rd_act_r <= rd_act;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write capture while strobe is low, held for the commit
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      wr_addr_r <= '0;
      wr_data_r <= DATA_W'(HPBP_REG_RESET);
    end
    else if (wr_act)
    begin
      wr_addr_r <= REGISTER_SELECT_IN;
      wr_data_r <= HOST_DATA_BUS_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register store, written only at a commit
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      for (int i = 0; i < NREG; i++)
        regs_r[i] <= DATA_W'(HPBP_REG_RESET);
    end
    else if (wr_rise)
    begin
      regs_r[wr_addr_r] <= wr_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered bus drive
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      dout_r <= DATA_W'(HPBP_IDLE_DATA);
      oe_r <= 1'b0;
    end
    else
    begin
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event pulses, one cycle each
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rd_start_r <= 1'b0;
      wr_done_r <= 1'b0;
    end
    else
    begin
      rd_start_r <= rd_fall;
      wr_done_r <= wr_rise;
    end
  end

  assign HOST_DATA_BUS_OUT = dout_r;
  assign HOST_DATA_BUS_OE_OUT = oe_r;
  assign READ_START_OUT = rd_start_r;
  assign WRITE_DONE_OUT = wr_done_r;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_release_on_deselect: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    CHIP_SELECT_N_IN |=> !HOST_DATA_BUS_OE_OUT)
    else $error("data bus driven while deselected");

  chk_drive_on_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    rd_act |=> HOST_DATA_BUS_OE_OUT && HOST_DATA_BUS_OUT == $past(regs_r[REGISTER_SELECT_IN]))
    else $error("read data not driven");

  chk_no_drive_idle: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !rd_act |=> !HOST_DATA_BUS_OE_OUT)
    else $error("bus driven without read");

  chk_write_commit: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    wr_rise |=> regs_r[$past(wr_addr_r)] == $past(wr_data_r) && WRITE_DONE_OUT)
    else $error("write not committed at strobe rise");

  chk_write_only_rise: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !wr_rise |=> !WRITE_DONE_OUT)
    else $error("write pulse without strobe rise");

  chk_read_start: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (rd_act && !$past(rd_act)) |=> READ_START_OUT ##1 !READ_START_OUT)
    else $error("read start pulse wrong");

  chk_dir_exclusive: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    both_low |=> !HOST_DATA_BUS_OE_OUT)
    else $error("bus driven with both strobes low");

  chk_data_order: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    wr_act |=> wr_data_r[HPBP_DATA_MSB] == $past(HOST_DATA_BUS_IN[HPBP_DATA_MSB])
      && wr_data_r[HPBP_DATA_LSB] == $past(HOST_DATA_BUS_IN[HPBP_DATA_LSB]))
    else $error("bit order broken");

  chk_refused_no_write: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (both_low && !wr_act_r) |=> !WRITE_DONE_OUT)
    else $error("write committed with both strobes low");

  chk_write_capture: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    wr_act |=> wr_addr_r == $past(REGISTER_SELECT_IN))
    else $error("write address not captured");

  chk_store_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !wr_rise |=> regs_r[$past(REGISTER_SELECT_IN)] == $past(rd_word))
    else $error("register changed without commit");

  chk_read_no_commit: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (rd_act && !wr_act_r) |=> !WRITE_DONE_OUT)
    else $error("read caused a write commit");

  chk_done_single: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    WRITE_DONE_OUT |=> !WRITE_DONE_OUT)
    else $error("write pulse longer than one cycle");

  chk_idle_data_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !HOST_DATA_BUS_OE_OUT |-> HOST_DATA_BUS_OUT == DATA_W'(HPBP_IDLE_DATA))
    else $error("data not idle while released");

  chk_oe_follows_read: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    HOST_DATA_BUS_OE_OUT |-> $past(rd_act))
    else $error("bus driven without a read");

  chk_start_needs_select: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    READ_START_OUT |-> $past(rd_act))
    else $error("read start without selected read");

  chk_start_only_fall: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !rd_fall |=> !READ_START_OUT)
    else $error("read start without strobe fall");

endmodule : hpbp_port
`default_nettype wire

// >>> hpbp_host.sv
// Host CPU model for the parallel bus port
`default_nettype none
module hpbp_host
(
  input wire logic clk_in, // Clock
  input wire logic [7:0] bus_in, // Resolved bus
  output logic cs_n_out, // Chip select
  output logic rd_n_out, // Read strobe
  output logic wr_n_out, // Write strobe
  output logic [5:0] a_out, // Register select
  output logic [7:0] d_out, // Write data
  output logic oe_out // Host drives bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cs_n_out, rd_n_out, wr_n_out, a_out, d_out, oe_out} = 18'h38000;
  // One access held n cycles, bus sampled before release
  task automatic acc(input logic [2:0] c, input logic [5:0] a, input logic [7:0] d, input int n,
    output logic [7:0] q);
    @(negedge clk_in);
    {cs_n_out, rd_n_out, wr_n_out, a_out, d_out, oe_out} = {c, a, d, ~c[0]};
    repeat (n) @(negedge clk_in);
    q = bus_in;
    {cs_n_out, rd_n_out, wr_n_out, oe_out} = 4'he;
  endtask : acc
endmodule : hpbp_host
`default_nettype wire

// >>> hpbp_port_bench.sv
// Self-checking bench for the host parallel bus port
`default_nettype none
module hpbp_port_bench
  import hpbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn, cs_n, rd_n, wr_n, h_oe, d_oe, rs, wd;
  logic [5:0] a;
  logic [7:0] idle = 8'h5a;
  logic [7:0] hd, dd, q, bus, e [64];
  int error_cnt, check_count, n_rs, n_wd, n_oe;
  assign bus = d_oe ? dd : (h_oe ? hd : idle);
  hpbp_host hpbp_host_i (.clk_in(clk), .bus_in(bus), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .a_out(a), .d_out(hd), .oe_out(h_oe));
  hpbp_port hpbp_port_i (.REF_CLK_IN(clk), .RESETN_IN(rstn), .CHIP_SELECT_N_IN(cs_n), .READ_STROBE_N_IN(rd_n),
    .WRITE_STROBE_N_IN(wr_n), .REGISTER_SELECT_IN(a), .HOST_DATA_BUS_IN(bus), .HOST_DATA_BUS_OUT(dd),
    .HOST_DATA_BUS_OE_OUT(d_oe), .READ_START_OUT(rs), .WRITE_DONE_OUT(wd));
  always @(posedge clk)
  begin
    idle <= ~idle;
    n_rs <= n_rs + int'(rs === 1'b1);
    n_wd <= n_wd + int'(wd === 1'b1);
    n_oe <= n_oe + int'(d_oe === 1'b1);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    check_count++;
    if (g !== x)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic rd(input logic [5:0] r);
    hpbp_host_i.acc(3'b001, r, 8'h00, 2, q);
    chk(q, e[r]);
  endtask : rd
  task automatic t_rw;
    logic [5:0] r [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};
    logic [7:0] v [4] = '{8'h01, 8'h80, 8'ha5, 8'h5a};
    for (int i = 0; i < 4; i++)
    begin
      hpbp_host_i.acc(3'b010, r[i], v[i], i + 1, q);
      e[r[i]] = v[i];
    end
    for (int i = 0; i < 4; i++) rd(r[i]);
    rd(6'h01);
    chk(8'(n_wd), 8'h04);
    chk(8'(n_rs), 8'h05);
    $display("t_rw done");
  endtask : t_rw
  task automatic t_refuse;
    int o;
    int w;
    repeat (2) @(negedge clk);
    o = n_oe;
    w = n_wd;
    hpbp_host_i.acc(3'b101, 6'h00, 8'h00, 3, q);
    hpbp_host_i.acc(3'b110, 6'h00, 8'hff, 3, q);
    hpbp_host_i.acc(3'b000, 6'h3f, 8'h00, 3, q);
    repeat (2) @(negedge clk);
    chk(8'(n_oe - o), 8'h00);
    chk(8'(n_wd - w), 8'h00);
    rd(6'h00);
    rd(6'h3f);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    foreach (e[i]) e[i] = HPBP_REG_RESET;
    rd(6'h3f);
    rd(6'h2a);
    $display("t_reset done");
  endtask : t_reset
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial forever #2.5 clk = ~clk;
  initial
  begin
    rstn = 1'b0;
    foreach (e[i]) e[i] = HPBP_REG_RESET;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_rw();
    t_refuse();
    t_reset();
    end_of_test();
  end
  initial
  begin
    #20us;
    error_cnt++;
    end_of_test();
  end
endmodule : hpbp_port_bench
`default_nettype wire
